//--- hdl/link_mode_pkg.sv
// Purpose: shared constants for the mode and channel linkage block
// Assumes: 8-bit multiplexed host bus, 14 channel register sets
// Notes:   bit positions in the command and status bytes are local choices
package link_mode_pkg;
  // ********************************************************
  // register offsets
  // ********************************************************
  localparam logic [7:0] cmd_off      = 8'h03;
  localparam logic [7:0] lstat_off    = 8'h04;
  // channel register sets: base + index * stride
  localparam logic [7:0] chan_base    = 8'h10;
  localparam int         chan_stride  = 8;
  localparam int         chan_num     = 14;
  localparam logic [2:0] tag_off      = 3'h0;
  localparam logic [2:0] ptr_off      = 3'h2;
  localparam logic [2:0] len_off      = 3'h3;
  localparam int         ptr_w        = 7;
  localparam int         len_w        = 5;
  localparam int         chan_w       = 4;

  // ********************************************************
  // field positions
  // ********************************************************
  localparam int activate_command_bit_bit   = 0;
  localparam int idle_bit   = 1;
  localparam int sleep_bit  = 2;
  localparam int st_idle    = 0;
  localparam int st_active  = 1;
  localparam int st_sleep   = 2;

  localparam logic [7:0] cmd_rst = 8'h02;

  typedef enum logic [1:0] {
    mode_idle,
    mode_active,
    mode_sleep
  } mode_t;
endpackage

//--- hdl/regmem_if.sv
`timescale 1ns/1ps
// Purpose: carrier between the bus logic and the register memory
// Assumes: one write or read address per cycle
// Notes:   read data arrive one cycle after the address
interface regmem_if #(parameter int aw = 8, parameter int dw = 8);
  logic          we;
  logic [aw-1:0] addr;
  logic [dw-1:0] wdata;
  logic [dw-1:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem  (input we, input addr, input wdata, output rdata);
endinterface

//--- hdl/reg_ram.sv
`timescale 1ns/1ps
// Purpose: byte memory behind the host bus (user registers and buffers)
// Assumes: synchronous write, registered read
// Notes:   contents are not cleared by reset, like any ram
module reg_ram #(
  parameter int depth = 256
) (
  // clock
  input wire logic mclk,
  // access port
  regmem_if.mem    port
);
  logic [7:0] mem [depth];
  logic [7:0] rdata_q;

  always_ff @(posedge mclk) begin
    if (port.we) begin
      mem[port.addr] <= port.wdata;
    end
    rdata_q <= mem[port.addr];
  end

  assign port.rdata = rdata_q;
endmodule // reg_ram

//--- hdl/van_mode_link.sv
`timescale 1ns/1ps
// Purpose: operating modes and channel linkage for a serial bus controller
// Assumes: host strobes are asynchronous to mclk and held several cycles
// Notes:   mclk keeps running in sleep; osc_run shows the oscillator state

// What this block does
// RULE1 - after any reset the block starts in idle mode
// RULE2 - idle keeps oscillator and clock output; no frames sent or received
// RULE3 - in idle the line transmit output is released to high impedance
// RULE4 - host activates by writing activate bit set and idle bit clear
// RULE5 - line status register reports whether the block is idle
// RULE6 - sleep bit set enters sleep whatever activate and idle bits say
// RULE7 - entering sleep stops oscillator, forces low-power state at once
// RULE8 - all host registers stay readable and writable during sleep
// RULE9 - sleep ends when the host sets the idle or activate bit
// RULE10 - a channel with zero message length is linked to another channel
// RULE11 - a linked channel's pointer field names the channel it shares
// RULE12 - a linked pair takes buffer pointer and length from the target only
// RULE13 - host links only one level; never to a channel itself linked
// RULE14 - each channel of a pair keeps its own settings such as its tag
// RULE15 - buffer transfers of linked channels use the target's address range
module van_mode_link #(
  parameter int nchan = link_mode_pkg::chan_num
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // multiplexed host bus
  input  wire logic       ale,
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [7:0] ad_in,
  output logic      [7:0] ad_out,
  output logic            ad_oe,
  // line side
  input  wire logic       tx_bit,
  output logic            txd_out,
  output logic            txd_oe,
  output logic            rx_enable,
  // clock control
  output logic            osc_run,
  output logic            clk_out_en,
  output logic            low_power,
  // buffer transfer lookup
  input  wire logic [3:0] dma_chan,
  input  wire logic [6:0] dma_index,
  output logic      [6:0] dma_addr,
  output logic      [4:0] dma_len,
  output logic      [7:0] dma_tag,
  output logic            dma_linked
);
  // ********************************************************
  // reset and pin synchronisers
  // ********************************************************
  logic [1:0] rst_q;
  logic       rst_n;
  logic [1:0] ale_q, cs_q, rd_q, wr_q;
  logic [7:0] ad_s1_q, ad_s2_q;
  logic       ale_d1_q, wr_d1_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ale_q    <= 2'h0;
      cs_q     <= 2'h3;
      rd_q     <= 2'h3;
      wr_q     <= 2'h3;
      ad_s1_q  <= 8'h00;
      ad_s2_q  <= 8'h00;
      ale_d1_q <= 1'b0;
      wr_d1_q  <= 1'b1;
    end else begin
      ale_q    <= {ale_q[0], ale};
      cs_q     <= {cs_q[0], cs_n};
      rd_q     <= {rd_q[0], rd_n};
      wr_q     <= {wr_q[0], wr_n};
      ad_s1_q  <= ad_in;
      ad_s2_q  <= ad_s1_q;
      ale_d1_q <= ale_q[1];
      wr_d1_q  <= wr_q[1];
    end
  end

  // ********************************************************
  // bus decode
  // ********************************************************
  logic [7:0] addr_q;
  wire        ale_fall = ale_d1_q && !ale_q[1];
  wire        wr_rise  = !wr_d1_q && wr_q[1];
  wire        sel      = !cs_q[1];
  wire        wr_stb   = wr_rise && sel;
  wire        rd_act   = !rd_q[1] && sel;
  wire        hit_cmd  = addr_q == link_mode_pkg::cmd_off;
  wire        hit_lst  = addr_q == link_mode_pkg::lstat_off;
  // offset inside the channel area and the channel it belongs to
  wire [7:0]  chan_rel = addr_q - link_mode_pkg::chan_base;
  wire [4:0]  chan_idx = chan_rel[7:3];
  wire [2:0]  chan_fld = chan_rel[2:0];
  wire        in_chan  = (addr_q >= link_mode_pkg::chan_base) &&
                         (chan_idx < 5'(nchan));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= 8'h00;
    end else if (ale_fall) begin
      addr_q <= ad_s2_q;
    end
  end

  // ********************************************************
  // register memory
  // ********************************************************
  // writes land in memory whatever the mode, so sleep never blocks access
  regmem_if #(.aw(8), .dw(8)) mem_bus ();
  assign mem_bus.we    = wr_stb; // RULE8
  assign mem_bus.addr  = addr_q;
  assign mem_bus.wdata = ad_s2_q;

  reg_ram #(.depth(256)) u_ram (
    .mclk (mclk),
    .port (mem_bus.mem)
  );

  // ********************************************************
  // mode control
  // ********************************************************
  link_mode_pkg::mode_t mode_q, mode_d;
  logic [7:0]           cmd_q;
  wire [7:0]            wd = ad_s2_q;
  wire                  cmd_wr = wr_stb && hit_cmd;

  always_comb begin
    mode_d = mode_q;
    if (cmd_wr) begin
      if (wd[link_mode_pkg::sleep_bit]) begin
        mode_d = link_mode_pkg::mode_sleep; // RULE6
      end else if (wd[link_mode_pkg::idle_bit]) begin
        mode_d = link_mode_pkg::mode_idle; // RULE9
      end else if (wd[link_mode_pkg::activate_command_bit_bit]) begin
        mode_d = link_mode_pkg::mode_active; // RULE4 RULE9
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= link_mode_pkg::mode_idle; // RULE1
      cmd_q  <= link_mode_pkg::cmd_rst;
    end else begin
      mode_q <= mode_d;
      if (cmd_wr) begin
        cmd_q <= wd;
      end
    end
  end

  wire is_idle   = mode_d == link_mode_pkg::mode_idle;
  wire is_active = mode_d == link_mode_pkg::mode_active;
  wire is_sleep  = mode_d == link_mode_pkg::mode_sleep;

  // outputs follow the next mode so sleep takes hold on the write edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      osc_run    <= 1'b1;
      clk_out_en <= 1'b1;
      low_power  <= 1'b0;
      rx_enable  <= 1'b0;
      txd_oe     <= 1'b0;
      txd_out    <= 1'b1;
    end else begin
      osc_run    <= !is_sleep; // RULE2 RULE7
      clk_out_en <= !is_sleep; // RULE2
      low_power  <= is_sleep; // RULE7
      rx_enable  <= is_active; // RULE2
      txd_oe     <= is_active; // RULE3
      txd_out    <= is_active ? tx_bit : 1'b1; // RULE2
    end
  end

  // ********************************************************
  // channel shadows
  // ********************************************************
  logic [6:0] ptr_q [nchan];
  logic [4:0] len_q [nchan];
  logic [7:0] tag_q [nchan];

  for (genvar c = 0; c < nchan; c++) begin : g_chan
    wire mine = wr_stb && in_chan && (chan_idx == 5'(c));
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        ptr_q[c] <= 7'h00;
        len_q[c] <= 5'h00;
        tag_q[c] <= 8'h00;
      end else if (mine) begin
        if (chan_fld == link_mode_pkg::ptr_off) ptr_q[c] <= wd[6:0];
        if (chan_fld == link_mode_pkg::len_off) len_q[c] <= wd[4:0];
        if (chan_fld == link_mode_pkg::tag_off) tag_q[c] <= wd;
      end
    end
  end

  // ********************************************************
  // linkage resolution
  // ********************************************************
  // one lookup only: a target that is itself linked is not followed
  wire [3:0] req_ch  = (dma_chan < 4'(nchan)) ? dma_chan : 4'h0;
  wire       linked  = len_q[req_ch] == 5'h00; // RULE10
  wire [6:0] tgt_raw = ptr_q[req_ch]; // RULE11
  wire [3:0] tgt_ch  = (tgt_raw < 7'(nchan)) ? tgt_raw[3:0] : 4'h0; // RULE13
  wire [3:0] own_ch  = linked ? tgt_ch : req_ch;
  wire [6:0] buf_ptr = ptr_q[own_ch]; // RULE12
  wire [4:0] buf_len = len_q[own_ch]; // RULE12

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dma_addr   <= 7'h00;
      dma_len    <= 5'h00;
      dma_tag    <= 8'h00;
      dma_linked <= 1'b0;
    end else begin
      dma_addr   <= 7'(buf_ptr + dma_index); // RULE15
      dma_len    <= buf_len; // RULE15
      dma_tag    <= tag_q[req_ch]; // RULE14
      dma_linked <= linked;
    end
  end

  // ********************************************************
  // read path
  // ********************************************************
  wire [7:0] lstat = {5'h00, is_sleep, is_active, is_idle}; // RULE5
  wire [7:0] rd_mux = hit_cmd ? cmd_q :
                      hit_lst ? lstat : mem_bus.rdata;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ad_out <= 8'h00;
      ad_oe  <= 1'b0;
    end else begin
      ad_out <= rd_mux; // RULE8
      ad_oe  <= rd_act;
    end
  end
endmodule // van_mode_link

//--- test/van_mode_link_properties.sv
`timescale 1ns/1ps
// Purpose: port-level checks of modes and host read timing
// Assumes: mode outputs move only on command writes
// Notes:   bound to every van_mode_link instance
module van_mode_link_properties (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // host strobes
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ad_oe,
  // line and clock control
  input wire logic txd_out,
  input wire logic txd_oe,
  input wire logic rx_enable,
  input wire logic osc_run,
  input wire logic clk_out_en,
  input wire logic low_power
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_reset_idle;
    $rose(nrst) |-> (!txd_oe && osc_run && !low_power)[*3];
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("not idle after reset");
  property p_sleep_off;
    low_power |-> !osc_run && !clk_out_en && !rx_enable;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("oscillator runs in sleep");
  property p_awake_clk;
    !low_power |-> osc_run && clk_out_en;
  endproperty
  a_awake_clk: assert property (p_awake_clk)
    else $error("clock stopped outside sleep");
  property p_rx_tx;
    rx_enable |-> txd_oe;
  endproperty
  a_rx_tx: assert property (p_rx_tx)
    else $error("receiver on while transmitter off");
  property p_txd_hiz;
    !txd_oe |-> txd_out && !rx_enable;
  endproperty
  a_txd_hiz: assert property (p_txd_hiz)
    else $error("line output wrong while released");
  property p_sleep_on_write;
    $rose(low_power) |-> !cs_n && wr_n;
  endproperty
  a_sleep_on_write: assert property (p_sleep_on_write)
    else $error("sleep entered outside a write");
  property p_oe_rise;
    $rose(ad_oe) |-> $past(rd_n, 2) == 1'b0 && $past(cs_n, 2) == 1'b0;
  endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("bus driven without a read");
  property p_oe_fall;
    $fell(ad_oe) |-> $past(rd_n, 2);
  endproperty
  a_oe_fall: assert property (p_oe_fall)
    else $error("bus released during a read");
endmodule // van_mode_link_properties

bind van_mode_link van_mode_link_properties u_props (
  .mclk(mclk), .nrst(nrst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
  .ad_oe(ad_oe), .txd_out(txd_out), .txd_oe(txd_oe),
  .rx_enable(rx_enable), .osc_run(osc_run), .clk_out_en(clk_out_en),
  .low_power(low_power));

//--- test/host_model.sv
`timescale 1ns/1ps
// Purpose: host processor on the multiplexed byte bus
// Assumes: every level held at least 4 mclk cycles
// Notes:   released data lines show the inverse of the last byte
module host_model (
  // clock
  input  wire logic       mclk,
  // bus
  output logic            ale,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic      [7:0] ad_in,
  input  wire logic [7:0] ad_out,
  input  wire logic       ad_oe
);
  initial begin
    ale = 1'b0;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    ad_in = 8'h00;
  end
  task automatic addr_phase(input logic [7:0] a);
    ale = 1'b1;
    ad_in = a;
    repeat (4) @(negedge mclk);
    ale = 1'b0;
    repeat (4) @(negedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_phase(a);
    ad_in = d;
    cs_n = 1'b0;
    wr_n = 1'b0;
    repeat (6) @(negedge mclk);
    wr_n = 1'b1;
    repeat (6) @(negedge mclk);
    cs_n = 1'b1;
    ad_in = ~d;
    repeat (4) @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output bit ok);
    addr_phase(a);
    ad_in = ~a;
    cs_n = 1'b0;
    rd_n = 1'b0;
    ok = 1'b0;
    d = 8'hxx;
    for (int i = 0; i < 12 && !ok; i++) begin
      @(negedge mclk);
      ok = (ad_oe === 1'b1);
    end
    repeat (2) @(negedge mclk);
    if (ok) d = ad_out;
    rd_n = 1'b1;
    repeat (2) @(negedge mclk);
    cs_n = 1'b1;
    repeat (4) @(negedge mclk);
  endtask
endmodule // host_model

//--- test/testbench.sv
`timescale 1ns/1ps
// Purpose: self-checking bench for modes and channel linkage
// Assumes: idle pins 26, active 1e (tx bit 0), sleep 21 in the pins() pack
// Notes:   inputs change on the falling edge of mclk
module testbench;
  logic mclk = 1'b0, nrst = 1'b0, ale, cs_n, rd_n, wr_n, ad_oe, txd_out;
  logic txd_oe, rx_enable, osc_run, clk_out_en, low_power, dma_linked;
  logic [7:0] ad_in, ad_out, dma_tag;
  logic tx_bit = 1'b0;
  logic [3:0] dma_chan = 4'h0;
  logic [6:0] dma_index = 7'h00, dma_addr;
  logic [4:0] dma_len;
  int num_errors = 0;
  int samples_checked = 0;
  always #10 mclk = ~mclk;
  van_mode_link u_dut (.mclk(mclk), .nrst(nrst), .ale(ale), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .ad_in(ad_in), .ad_out(ad_out),
    .ad_oe(ad_oe), .tx_bit(tx_bit), .txd_out(txd_out), .txd_oe(txd_oe),
    .rx_enable(rx_enable), .osc_run(osc_run), .clk_out_en(clk_out_en),
    .low_power(low_power), .dma_chan(dma_chan), .dma_index(dma_index),
    .dma_addr(dma_addr), .dma_len(dma_len), .dma_tag(dma_tag),
    .dma_linked(dma_linked));
  host_model u_host (.mclk(mclk), .ale(ale), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe));
  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bit ok;
    u_host.rd(a, d, ok);
    if (!ok) begin
      num_errors++;
      $display("[FAIL] %0t read got no answer", $time);
      wrap_up();
    end else begin
      chk(d, exp);
    end
  endtask
  function automatic logic [7:0] pins();
    return {2'h0, txd_out, txd_oe, rx_enable, osc_run, clk_out_en,
            low_power};
  endfunction
  task automatic dma_chk(input logic [3:0] c, input logic [6:0] i,
                         input logic [7:0] a, l, t, k);
    dma_chan = c;
    dma_index = i;
    repeat (2) @(negedge mclk);
    chk({1'b0, dma_addr}, a);
    chk({3'h0, dma_len}, l);
    chk(dma_tag, t);
    chk({7'h00, dma_linked}, k);
  endtask
  task automatic t_reset();
    chk(pins(), 8'h26);
    rdc(8'h03, 8'h02);
    rdc(8'h04, 8'h01);
  endtask
  task automatic t_modes();
    u_host.wr(8'h03, 8'h03);
    rdc(8'h04, 8'h01);
    u_host.wr(8'h03, 8'h01);
    rdc(8'h04, 8'h02);
    chk(pins(), 8'h1e);
    tx_bit = 1'b1;
    repeat (2) @(negedge mclk);
    chk(pins(), 8'h3e);
    tx_bit = 1'b0;
    u_host.wr(8'h03, 8'h07);
    rdc(8'h04, 8'h04);
    chk(pins(), 8'h21);
    u_host.wr(8'h03, 8'h00);
    u_host.wr(8'h10, 8'h3c);
    rdc(8'h10, 8'h3c);
    rdc(8'h03, 8'h00);
    rdc(8'h04, 8'h04);
    u_host.wr(8'h03, 8'h02);
    chk(pins(), 8'h26);
    u_host.wr(8'h03, 8'h04);
    u_host.wr(8'h03, 8'h01);
    rdc(8'h04, 8'h02);
  endtask
  task automatic t_link();
    u_host.wr(8'h18, 8'h5a);
    u_host.wr(8'h1a, 8'h20);
    u_host.wr(8'h1b, 8'h08);
    u_host.wr(8'h28, 8'ha5);
    u_host.wr(8'h2a, 8'h01);
    u_host.wr(8'h2b, 8'h00);
    dma_chk(4'h3, 7'h02, 8'h22, 8'h08, 8'ha5, 8'h01);
    dma_chk(4'h1, 7'h05, 8'h25, 8'h08, 8'h5a, 8'h00);
    // out-of-range channel index falls back to channel 0
    dma_chk(4'hf, 7'h04, 8'h04, 8'h00, 8'h3c, 8'h01);
  endtask
  task automatic t_rereset();
    nrst = 1'b0;
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    chk(pins(), 8'h26);
    rdc(8'h03, 8'h02);
  endtask
  initial begin
    repeat (8) @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    t_reset();
    t_modes();
    t_link();
    t_rereset();
    wrap_up();
  end
endmodule // testbench
